//--- pkg/ram_ctl_pkg.sv
`default_nettype none
package ram_ctl_pkg;
  localparam int DATA_W   = 16;
  localparam int LANE_W   = 8;
  localparam int LANES    = DATA_W / LANE_W;
  localparam int ADDR_W   = 8;
  localparam int DIE_W    = 2;
  localparam int DIE_CNT  = 3;

  // Die slots in the shared store
  localparam logic [DIE_W-1:0] DIE_PSRAM1 = 2'h0;
  localparam logic [DIE_W-1:0] DIE_PSRAM2 = 2'h1;
  localparam logic [DIE_W-1:0] DIE_SRAM   = 2'h2;

  // Lane positions
  localparam int LANE_LOW   = 0;
  localparam int LANE_UPPER = 1;

  // Configuration register selection and fields
  localparam int CFG_SEL_BIT      = 0;
  localparam logic CFG_SEL_REFRESH = 1'b0;
  localparam int LOW_POWER_BIT    = 0;
  localparam logic [DATA_W-1:0] REFRESH_CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BUS_CTRL_RESET     = 16'h0000;
  localparam logic              LOW_POWER_RESET    = 1'b0;

  // Read pipeline: address edge to data on the pins
  localparam int READ_LATENCY_CYCLES = 2;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_FETCH,
    RD_LOAD,
    RD_PRESENT
  } rd_state_type;
endpackage
`default_nettype wire

//--- rtl/ram_store.sv
`timescale 1ns/100ps
`default_nettype none
module ram_store #(
  parameter int WIDTH  = 16,
  parameter int LANE_W = 8,
  parameter int AW     = 10
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_clk_en,
  input  wire logic [AW-1:0]            i_addr,
  input  wire logic [WIDTH/LANE_W-1:0]  i_lane_we,
  input  wire logic [WIDTH-1:0]         i_wdata,
  output logic      [WIDTH-1:0]         o_rdata
);
  // ****************************************
  // Byte-lane storage
  // ****************************************
  for (genvar l = 0; l < WIDTH / LANE_W; l++) begin : g_lane
    // One array per lane, so each array has a single writing process
    logic [LANE_W-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clock) begin
      if (i_clk_en && i_lane_we[l]) begin
        mem[i_addr] <= i_wdata[l*LANE_W +: LANE_W];
      end
    end

    // Registered read, one cycle behind the address
    always_ff @(posedge i_clock) begin
      if (i_clk_en) begin
        o_rdata[l*LANE_W +: LANE_W] <= mem[i_addr];
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/ram_die_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ram_die_ctrl
  import ram_ctl_pkg::*;
#(
  parameter logic WAIT_ACTIVE_HIGH = 1'b1
) (
  input  wire logic                         I_CLOCK,
  input  wire logic                         I_RST,
  input  wire logic                         I_CLK_EN,
  input  wire logic                         I_ASYNC_VARIANT,
  input  wire logic [1:0]                   I_PSRAM_DIE_SELECT_N,
  input  wire logic                         I_SRAM_SELECT_LOW_N,
  input  wire logic                         I_SRAM_SELECT_HIGH,
  input  wire logic                         I_RAM_OUTPUT_EN_N,
  input  wire logic                         I_RAM_WR_STROBE_N,
  input  wire logic                         I_UPPER_BYTE_EN_N,
  input  wire logic                         I_LOWER_BYTE_EN_N,
  input  wire logic                         I_PSRAM_CFG_REG_SELECT,
  input  wire logic                         I_ADDR_VALID_N,
  input  wire logic [ram_ctl_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [ram_ctl_pkg::DATA_W-1:0] I_DATA,
  input  wire logic                         I_FLASH_PROTECT_N,
  output logic      [ram_ctl_pkg::DATA_W-1:0] O_DATA,
  output logic      [ram_ctl_pkg::LANES-1:0]  O_DATA_OE,
  output logic                              O_WAIT,
  output logic                              O_WAIT_OE,
  output logic                              O_LOCKDOWN_ENFORCED,
  output logic      [ram_ctl_pkg::DIE_CNT-1:0] O_DIE_STANDBY,
  output logic                              O_LOW_POWER,
  output logic      [ram_ctl_pkg::DATA_W-1:0] O_REFRESH_CTRL_REG,
  output logic      [ram_ctl_pkg::DATA_W-1:0] O_BUS_CTRL_REG
);
  import ram_ctl_pkg::*;

  // ****************************************
  // Die selection
  // ****************************************
  logic [DIE_CNT-1:0]  sel_vec;
  logic                any_sel;
  logic                psram_sel;
  logic [DIE_W-1:0]    die_idx;
  logic                cfg_access;
  logic [LANES-1:0]    lane_en;
  logic                read_active;

  assign sel_vec[DIE_PSRAM1] = !I_PSRAM_DIE_SELECT_N[0];
  assign sel_vec[DIE_PSRAM2] = !I_PSRAM_DIE_SELECT_N[1];
  assign sel_vec[DIE_SRAM]   = !I_SRAM_SELECT_LOW_N && I_SRAM_SELECT_HIGH;
  assign any_sel   = |sel_vec;
  assign psram_sel = sel_vec[DIE_PSRAM1] || sel_vec[DIE_PSRAM2];
  // Overlapping selects are the controller's fault; lowest die wins
  assign die_idx   = sel_vec[DIE_PSRAM1] ? DIE_PSRAM1 :
                     sel_vec[DIE_PSRAM2] ? DIE_PSRAM2 : DIE_SRAM;
  // Shared ball: polarity depends on which die type is fitted
  assign cfg_access = psram_sel && (I_ASYNC_VARIANT ? !I_PSRAM_CFG_REG_SELECT
                                                    : I_PSRAM_CFG_REG_SELECT);
  assign lane_en[LANE_UPPER] = !I_UPPER_BYTE_EN_N;
  assign lane_en[LANE_LOW]   = !I_LOWER_BYTE_EN_N;
  assign read_active = any_sel && !I_RAM_OUTPUT_EN_N && I_RAM_WR_STROBE_N;

  // ****************************************
  // Address capture
  // ****************************************
  logic [ADDR_W-1:0] addr_reg;
  logic              addr_taken_reg;
  logic              addr_take;

  // Sync: first edge with valid low only; async: flows while low
  assign addr_take = I_CLK_EN && !I_ADDR_VALID_N
                     && (I_ASYNC_VARIANT || !addr_taken_reg);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      addr_reg       <= '0;
      addr_taken_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      addr_taken_reg <= !I_ADDR_VALID_N;
      if (addr_take) begin
        addr_reg <= I_ADDR;
      end
    end
  end

  // ****************************************
  // Write strobe and commit
  // ****************************************
  logic             strobe_prev_n_reg;
  logic             wr_commit;
  logic [LANES-1:0] mem_lane_we;
  logic             cfg_write;

  // Data is taken at the rising edge of the strobe
  assign wr_commit   = I_CLK_EN && !strobe_prev_n_reg && I_RAM_WR_STROBE_N
                       && any_sel;
  // Both lanes masked gives an all-zero enable: store untouched
  assign mem_lane_we = (wr_commit && !cfg_access) ? lane_en : '0;
  assign cfg_write   = wr_commit && cfg_access && (|lane_en);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      strobe_prev_n_reg <= 1'b1;
    end else if (I_CLK_EN) begin
      strobe_prev_n_reg <= I_RAM_WR_STROBE_N;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_REFRESH_CTRL_REG <= REFRESH_CTRL_RESET;
      O_BUS_CTRL_REG     <= BUS_CTRL_RESET;
      O_LOW_POWER        <= LOW_POWER_RESET;
    end else if (cfg_write) begin
      if (I_ASYNC_VARIANT) begin
        O_LOW_POWER <= I_DATA[LOW_POWER_BIT];
      end else if (addr_reg[CFG_SEL_BIT] == CFG_SEL_REFRESH) begin
        O_REFRESH_CTRL_REG <= I_DATA;
      end else begin
        O_BUS_CTRL_REG <= I_DATA;
      end
    end
  end

  // ****************************************
  // Array store
  // ****************************************
  logic [DATA_W-1:0] mem_rdata;

  ram_store #(
    .WIDTH  (DATA_W),
    .LANE_W (LANE_W),
    .AW     (DIE_W + ADDR_W)
  ) u_store (
    .i_clock  (I_CLOCK),
    .i_clk_en (I_CLK_EN),
    .i_addr   ({die_idx, addr_reg}),
    .i_lane_we(mem_lane_we),
    .i_wdata  (I_DATA),
    .o_rdata  (mem_rdata)
  );

  // ****************************************
  // Read sequence and pin drivers
  // ****************************************
  rd_state_type      rd_state_reg;
  rd_state_type      rd_state_next;
  logic              cfg_rd_reg;
  logic [DATA_W-1:0] cfg_value;

  assign cfg_value = addr_reg[CFG_SEL_BIT] == CFG_SEL_REFRESH ? O_REFRESH_CTRL_REG
                                                              : O_BUS_CTRL_REG;

  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE:    rd_state_next = read_active ? RD_FETCH : RD_IDLE;
      RD_FETCH:   rd_state_next = RD_LOAD;
      RD_LOAD:    rd_state_next = RD_PRESENT;
      RD_PRESENT: rd_state_next = RD_PRESENT;
      default:    rd_state_next = RD_IDLE;
    endcase
    // A new address restarts the fetch; a dropped read returns to RD_IDLE
    if (!read_active) begin
      rd_state_next = RD_IDLE;
    end else if (addr_take) begin
      rd_state_next = RD_FETCH;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rd_state_reg <= RD_IDLE;
      cfg_rd_reg   <= 1'b0;
      O_DATA       <= '0;
    end else if (I_CLK_EN) begin
      rd_state_reg <= rd_state_next;
      cfg_rd_reg   <= cfg_access;
      if (rd_state_reg == RD_LOAD) begin
        O_DATA <= cfg_rd_reg ? cfg_value : mem_rdata;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_DATA_OE <= '0;
      O_WAIT_OE <= 1'b0;
      O_WAIT    <= !WAIT_ACTIVE_HIGH;
    end else if (I_CLK_EN) begin
      O_DATA_OE <= read_active ? lane_en : '0;
      // Only the synchronous PSRAM owns the wait ball
      O_WAIT_OE <= read_active && psram_sel && !I_ASYNC_VARIANT;
      O_WAIT    <= (rd_state_next != RD_PRESENT) ~^ WAIT_ACTIVE_HIGH;
    end
  end

  // ****************************************
  // Die power state and flash protect
  // ****************************************
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_DIE_STANDBY       <= '1;
      O_LOCKDOWN_ENFORCED <= 1'b1;
    end else if (I_CLK_EN) begin
      O_DIE_STANDBY       <= ~sel_vec;
      O_LOCKDOWN_ENFORCED <= !I_FLASH_PROTECT_N;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  sequence s_strobe_low;
    I_CLK_EN && !I_RAM_WR_STROBE_N;
  endsequence
  sequence s_strobe_rise;
    I_CLK_EN && I_RAM_WR_STROBE_N;
  endsequence

  a_write_on_rise: assert property (wr_commit |-> $past(!I_RAM_WR_STROBE_N)
    && I_RAM_WR_STROBE_N) else $error("write committed without strobe rise");
  a_write_edge_seen: assert property (s_strobe_low ##1 s_strobe_rise ##0 any_sel
    |-> wr_commit) else $error("strobe rise not committed");
  a_lockdown_follow: assert property (I_CLK_EN |=>
    O_LOCKDOWN_ENFORCED == !$past(I_FLASH_PROTECT_N)) else $error("lock-down level wrong");
  a_cfg_no_array: assert property ((|mem_lane_we) |-> !(psram_sel
    && (I_PSRAM_CFG_REG_SELECT ^ I_ASYNC_VARIANT))) else $error("config access reached the array");
  a_low_power_set: assert property (cfg_write && I_ASYNC_VARIANT
    |=> O_LOW_POWER == $past(I_DATA[LOW_POWER_BIT])) else $error("low power not taken");
  a_standby_track: assert property (I_CLK_EN |=>
    O_DIE_STANDBY[DIE_PSRAM1] == $past(I_PSRAM_DIE_SELECT_N[0])) else $error("standby wrong");
  a_sram_select: assert property (I_CLK_EN
    && (I_SRAM_SELECT_LOW_N || !I_SRAM_SELECT_HIGH)
    |=> O_DIE_STANDBY[DIE_SRAM]) else $error("sram selected with a select deasserted");
  a_lane_mask: assert property (I_CLK_EN && I_UPPER_BYTE_EN_N
    |=> !O_DATA_OE[LANE_UPPER]) else $error("masked lane driven");
  a_wait_hiz: assert property (I_CLK_EN && (I_RAM_OUTPUT_EN_N || !any_sel)
    |=> !O_WAIT_OE) else $error("wait driven while idle");
  a_oe_gate: assert property (I_CLK_EN && I_RAM_OUTPUT_EN_N |=> O_DATA_OE == '0)
    else $error("data driven with output enable high");
  a_read_latency: assert property (I_CLK_EN && read_active && addr_take
    ##1 (I_CLK_EN && read_active && I_ADDR_VALID_N)[*2]
    |=> rd_state_reg == RD_PRESENT) else $error("read data late");
  a_addr_capture: assert property (addr_take |=> addr_reg == $past(I_ADDR))
    else $error("address not captured");
  a_no_lane_write: assert property ((|mem_lane_we)
    |-> !(I_UPPER_BYTE_EN_N && I_LOWER_BYTE_EN_N)) else $error("write with both lanes masked");
endmodule
`default_nettype wire

//--- bench/ram_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ram_host_model (
  input  wire logic        i_clock,
  input  wire logic        i_async,
  output logic [1:0]       o_psram_die_select_n,
  output logic             o_sram_select_low_n,
  output logic             o_sram_select_high,
  output logic             o_ram_output_en_n,
  output logic             o_ram_wr_strobe_n,
  output logic             o_upper_byte_en_n,
  output logic             o_lower_byte_en_n,
  output logic             o_psram_cfg_reg_select,
  output logic             o_addr_valid_n,
  output logic [7:0]       o_addr,
  output logic [15:0]      o_data
);
  logic cfg_on;
  // Shared ball: its true level flips with the fitted variant
  assign o_psram_cfg_reg_select = i_async ^ cfg_on;
  task automatic select_die(input int die, input logic on);
    o_psram_die_select_n = 2'h3;
    o_sram_select_low_n  = 1'b1;
    o_sram_select_high   = 1'b0;
    if (on && die < 2) o_psram_die_select_n[die] = 1'b0;
    if (on && die == 2) begin
      o_sram_select_low_n = 1'b0;
      o_sram_select_high  = 1'b1;
    end
  endtask
  // Idle levels keep unused control balls inactive
  task automatic idle();
    select_die(0, 1'b0);
    o_ram_output_en_n = 1'b1;
    o_ram_wr_strobe_n = 1'b1;
    o_upper_byte_en_n = 1'b1;
    o_lower_byte_en_n = 1'b1;
    cfg_on            = 1'b0;
  endtask
  task automatic address(input int die, input logic [7:0] a, input logic [1:0] ln, input logic c);
    select_die(die, 1'b1);
    o_addr         = a;
    o_addr_valid_n = 1'b0;
    {o_upper_byte_en_n, o_lower_byte_en_n} = ln;
    cfg_on         = c;
  endtask
  task automatic write_word(input int die, input logic [7:0] a, input logic [15:0] d,
                            input logic [1:0] ln, input logic c);
    @(negedge i_clock);
    address(die, a, ln, c);
    o_ram_wr_strobe_n = 1'b0;
    @(negedge i_clock);
    // Address hold is over: show its inverse, not a stale copy
    o_addr_valid_n    = 1'b1;
    o_addr            = ~a;
    o_ram_wr_strobe_n = 1'b1;
    o_data            = d;
    @(negedge i_clock);
    idle();
    o_data = ~d;
  endtask
  task automatic start_read(input int die, input logic [7:0] a, input logic [1:0] ln,
                            input logic c);
    @(negedge i_clock);
    address(die, a, ln, c);
    o_ram_output_en_n = 1'b0;
    @(negedge i_clock);
    o_addr_valid_n = 1'b1;
    o_addr         = ~a;
  endtask
  initial begin
    idle();
    o_addr_valid_n = 1'b1;
    o_addr         = 8'h00;
    o_data         = 16'h0000;
  end
endmodule
`default_nettype wire

//--- bench/ram_die_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ram_die_ctrl_bench;
  import ram_ctl_pkg::*;
  logic clk, rst, ce, async_v, protect_n, sl_n, sh, oe_n, we_n, ub_n, lb_n, cfg, av_n;
  logic [1:0] psel_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, q, rcr, bcr;
  logic [LANES-1:0] q_oe;
  logic [DIE_CNT-1:0] stby;
  logic w, w_oe, lock, lp;
  int bad_count = 0;
  int n_checks = 0;
  ram_host_model ram_host_model_inst (.i_clock(clk), .i_async(async_v),
    .o_psram_die_select_n(psel_n), .o_sram_select_low_n(sl_n), .o_sram_select_high(sh),
    .o_ram_output_en_n(oe_n), .o_ram_wr_strobe_n(we_n), .o_upper_byte_en_n(ub_n),
    .o_lower_byte_en_n(lb_n), .o_psram_cfg_reg_select(cfg), .o_addr_valid_n(av_n),
    .o_addr(addr), .o_data(wdata));
  ram_die_ctrl ram_die_ctrl_inst (.I_CLOCK(clk), .I_RST(rst), .I_CLK_EN(ce),
    .I_ASYNC_VARIANT(async_v), .I_PSRAM_DIE_SELECT_N(psel_n), .I_SRAM_SELECT_LOW_N(sl_n),
    .I_SRAM_SELECT_HIGH(sh), .I_RAM_OUTPUT_EN_N(oe_n), .I_RAM_WR_STROBE_N(we_n),
    .I_UPPER_BYTE_EN_N(ub_n), .I_LOWER_BYTE_EN_N(lb_n), .I_PSRAM_CFG_REG_SELECT(cfg),
    .I_ADDR_VALID_N(av_n), .I_ADDR(addr), .I_DATA(wdata), .I_FLASH_PROTECT_N(protect_n),
    .O_DATA(q), .O_DATA_OE(q_oe), .O_WAIT(w), .O_WAIT_OE(w_oe), .O_LOCKDOWN_ENFORCED(lock),
    .O_DIE_STANDBY(stby), .O_LOW_POWER(lp), .O_REFRESH_CTRL_REG(rcr), .O_BUS_CTRL_REG(bcr));
  // ****************************************
  // Checking and verdict
  // ****************************************
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read walk: wait asserted first, data checked three edges after the address edge
  task automatic rd(input int die, input logic [7:0] a, input logic [1:0] ln,
                    input logic [15:0] exp, input logic c);
    logic [15:0] m;
    logic [2:0]  s;
    logic        wt;
    m = {{8{~ln[1]}}, {8{~ln[0]}}};
    s = ~(3'h1 << die);
    // Only a synchronous PSRAM die owns the wait ball
    wt = die < 2 && !async_v;
    ram_host_model_inst.start_read(die, a, ln, c);
    @(negedge clk);
    chk(w_oe, wt);
    if (wt) chk(w, 1'b1);
    chk(stby, s);
    repeat (READ_LATENCY_CYCLES) @(negedge clk);
    chk(q & m, exp & m);
    chk(q_oe, {~ln[1], ~ln[0]});
    if (wt) chk(w, 1'b0);
    ram_host_model_inst.idle();
    repeat (2) @(negedge clk);
    chk({q_oe, w_oe, stby}, 6'h07);
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    async_v = 1'b0;
    protect_n = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk({lock, stby, lp, q_oe, w_oe}, 8'hF0);
    chk({q, rcr, bcr}, 48'h0);
    // Clock enable low must freeze the lock-down flop
    ce = 1'b0;
    protect_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(lock, 1'b1);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk(lock, 1'b0);
    protect_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(lock, 1'b1);
    // Same address on every die: each keeps its own word
    for (int d = 0; d < 3; d++) begin
      ram_host_model_inst.write_word(d, 8'h5A, 16'hA5C0 + d, 2'h0, 1'b0);
    end
    for (int d = 0; d < 3; d++) begin
      rd(d, 8'h5A, 2'h0, 16'hA5C0 + d, 1'b0);
    end
    ram_host_model_inst.write_word(0, 8'h5A, 16'h1234, 2'h1, 1'b0);
    ram_host_model_inst.write_word(0, 8'h5A, 16'h3456, 2'h2, 1'b0);
    ram_host_model_inst.write_word(0, 8'h5A, 16'hFFFF, 2'h3, 1'b0);
    rd(0, 8'h5A, 2'h0, 16'h1256, 1'b0);
    rd(1, 8'h5A, 2'h2, 16'hA5C1, 1'b0);
    // Half an SRAM select must leave the die in standby
    ram_host_model_inst.o_sram_select_low_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(stby, 3'h7);
    ram_host_model_inst.o_sram_select_low_n = 1'b1;
    ram_host_model_inst.o_sram_select_high  = 1'b1;
    repeat (2) @(negedge clk);
    chk(stby, 3'h7);
    ram_host_model_inst.idle();
    ram_host_model_inst.write_word(0, 8'h5A, 16'h00A5, 2'h0, 1'b1);
    ram_host_model_inst.write_word(0, 8'h5B, 16'h0B0C, 2'h0, 1'b1);
    repeat (2) @(negedge clk);
    chk({rcr, bcr}, 32'h00A5_0B0C);
    // Config reads come back on the data pins with array timing
    rd(0, 8'h5A, 2'h0, 16'h00A5, 1'b1);
    rd(0, 8'h5B, 2'h0, 16'h0B0C, 1'b1);
    async_v = 1'b1;
    ram_host_model_inst.write_word(0, 8'h5A, 16'h0001, 2'h0, 1'b1);
    repeat (2) @(negedge clk);
    chk(lp, 1'b1);
    ram_host_model_inst.write_word(0, 8'h5A, 16'h0000, 2'h0, 1'b1);
    repeat (2) @(negedge clk);
    chk(lp, 1'b0);
    // Async variant reads the array with the wait ball left off
    rd(1, 8'h5A, 2'h0, 16'hA5C1, 1'b0);
    async_v = 1'b0;
    rd(0, 8'h5A, 2'h0, 16'h1256, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
